// File: verilog/bcbe_core.sv
/*
 Execution of bit, compare-skip, branch, rotate, logic, add, load-immediate
 and table-read instructions, with an APB slave for control and status.
 Assumes the fetch side presents the word at prog_counter each step pulse,
 and that data memory and table memory answer combinationally.
*/
// The APB register port and the register addresses are this design's own decisions.
`default_nettype none
`include "bcbe_consts.svh"

module bcbe_core (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Instruction stream
   input  wire logic        step,
   input  wire logic [9:0]  instr,
   output logic      [9:0]  prog_counter,
   // Data memory at data_pointer
   input  wire logic [3:0]  mem_rdata,
   output logic      [3:0]  mem_wdata,
   output logic             mem_we,
   // Register E and table memory
   input  wire logic [3:0]  e_reg,
   input  wire logic [2:0]  tbl_page,
   output logic      [6:0]  tbl_addr,
   input  wire logic [9:0]  tbl_data,
   output logic             stack_use,
   // Core state
   output logic      [3:0]  acc,
   output logic             carry_flag,
   output logic             upper_ref_flag,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   function automatic logic pick_bit(input logic [3:0] w, input logic [1:0] j);
      pick_bit = w[j];
   endfunction : pick_bit

   function automatic logic [6:0] idx_low(input logic [9:0] w, input logic [3:0] a);
      idx_low = {w[`BCBE_IDX_HI:`BCBE_IDX_LO], a};
   endfunction : idx_low

   // ---------------------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign rst_n = rst_s2_q;

   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   bcbe_pkg::bcbe_state_e state_q;
   bcbe_pkg::bcbe_state_e state_d;
   bcbe_pkg::bcbe_pend_e  pend_q;
   bcbe_pkg::bcbe_pend_e  pend_d;
   logic [2:0]            page_q;
   logic [2:0]            page_d;
   logic [6:0]            low_q;
   logic [6:0]            low_d;
   logic [2:0]            ppage_q;
   logic [2:0]            ppage_d;
   logic [3:0]            acc_q;
   logic [3:0]            acc_d;
   logic                  cy_q;
   logic                  cy_d;
   logic                  urs_q;
   logic                  urs_d;
   logic                  skip_q;
   logic                  skip_d;
   logic                  kill_q;
   logic                  kill_d;
   logic                  ldi_q;
   logic                  ldi_d;
   logic                  stk_q;
   logic                  stk_d;
   logic [1:0]            fsel_q;

   logic [3:0] sum;
   logic       sum_carry;
   logic [3:0] rot;
   logic       rot_carry;
   logic [3:0] gate;
   logic       use_cy;
   logic [3:0] alu_opnd;

   assign use_cy   = (instr ==? `BCBE_OP_ADDC);
   assign alu_opnd = (instr ==? `BCBE_OP_ADDI) ? instr[3:0] :
                     (instr ==? `BCBE_OP_ADDC) ? mem_rdata : e_reg;

   bcbe_alu u_alu (
      .acc                  (acc_q),
      .opnd                 (alu_opnd),
      .carry_in             (cy_q),
      .use_carry            (use_cy),
      .gate_function_select (fsel_q),
      .sum                  (sum),
      .sum_carry            (sum_carry),
      .rot                  (rot),
      .rot_carry            (rot_carry),
      .gate                 (gate)
   );

   // ---------------------------------------------------------------------------
   // Decode and execute
   // ---------------------------------------------------------------------------
   logic two_word;
   logic is_ldi;

   assign two_word = (instr ==? `BCBE_OP_CMPI) || (instr ==? `BCBE_OP_BRL) ||
                     (instr ==? `BCBE_OP_BRA)  || (instr ==? `BCBE_OP_BRLA);
   assign is_ldi   = (instr ==? `BCBE_OP_LDI);
   assign tbl_addr = {tbl_page, acc_q};

   always_comb begin
      state_d   = state_q;
      pend_d    = pend_q;
      page_d    = page_q;
      low_d     = low_q + 7'h01;
      ppage_d   = ppage_q;
      acc_d     = acc_q;
      cy_d      = cy_q;
      urs_d     = urs_q;
      skip_d    = 1'b0;
      kill_d    = 1'b0;
      ldi_d     = ldi_q;
      stk_d     = 1'b0;
      mem_we    = 1'b0;
      mem_wdata = mem_rdata;
      if (state_q == bcbe_pkg::ST_SECOND) begin
         state_d = bcbe_pkg::ST_FIRST;
         ldi_d   = 1'b0;
         if (!kill_q) begin   // see (RL18)
            case (pend_q)
               bcbe_pkg::PK_CMPI: begin
                  skip_d = (acc_q == instr[3:0]);   // see (RL4)
               end
               bcbe_pkg::PK_BRL: begin
                  page_d = ppage_q;   // see (RL6)
                  low_d  = instr[6:0];
               end
               bcbe_pkg::PK_BRA: begin
                  low_d = idx_low(instr, acc_q);   // see (RL7)
               end
               default: begin
                  page_d = instr[2:0];   // see (RL8) (RL9)
                  low_d  = idx_low(instr, acc_q);
               end
            endcase
         end
      end else if (skip_q || (ldi_q && is_ldi)) begin   // see (RL12) (RL18)
         ldi_d = is_ldi;
         if (two_word) begin
            state_d = bcbe_pkg::ST_SECOND;
            kill_d  = 1'b1;
         end
      end else begin
         ldi_d = is_ldi;
         if (two_word) begin
            state_d = bcbe_pkg::ST_SECOND;
            ppage_d = instr[2:0];   // see (RL9)
         end
         casez (instr)
            `BCBE_OP_SETB: begin
               mem_we               = 1'b1;
               mem_wdata[instr[1:0]] = 1'b1;   // see (RL1)
            end
            `BCBE_OP_CLRB: begin
               mem_we               = 1'b1;
               mem_wdata[instr[1:0]] = 1'b0;   // see (RL2)
            end
            `BCBE_OP_SKBZ: begin
               skip_d = !pick_bit(mem_rdata, instr[1:0]);   // see (RL3)
            end
            `BCBE_OP_CMPM: begin
               skip_d = (acc_q == mem_rdata);   // see (RL4)
            end
            `BCBE_OP_CMPI: begin
               pend_d = bcbe_pkg::PK_CMPI;
            end
            `BCBE_OP_BR: begin
               low_d = instr[6:0];   // see (RL5)
            end
            `BCBE_OP_BRL: begin
               pend_d = bcbe_pkg::PK_BRL;
            end
            `BCBE_OP_BRA: begin
               pend_d = bcbe_pkg::PK_BRA;
            end
            `BCBE_OP_BRLA: begin
               pend_d = bcbe_pkg::PK_BRLA;
            end
            `BCBE_OP_ROT: begin
               acc_d = rot;   // see (RL10)
               cy_d  = rot_carry;
            end
            `BCBE_OP_LOGIC: begin
               acc_d = gate;   // see (RL11)
            end
            `BCBE_OP_LDI: begin
               acc_d = instr[3:0];
            end
            `BCBE_OP_ADDI: begin
               acc_d  = sum;   // see (RL15)
               skip_d = !sum_carry;
            end
            `BCBE_OP_ADDC: begin
               acc_d = sum;   // see (RL16)
               cy_d  = sum_carry;
            end
            `BCBE_OP_SKCZ: begin
               skip_d = !cy_q;   // see (RL17)
            end
            `BCBE_OP_TBL: begin
               acc_d = tbl_data[3:0];   // see (RL13)
               stk_d = 1'b1;
               if (urs_q) begin
                  cy_d = tbl_data[`BCBE_TBL_CY_BIT];   // see (RL14)
               end
            end
            `BCBE_OP_URSET: begin
               urs_d = 1'b1;   // see (RL14)
            end
            default: begin
               acc_d = acc_q;
            end
         endcase
      end
      if (!step) begin
         state_d   = state_q;
         pend_d    = pend_q;
         page_d    = page_q;
         low_d     = low_q;
         ppage_d   = ppage_q;
         acc_d     = acc_q;
         cy_d      = cy_q;
         urs_d     = urs_q;
         skip_d    = skip_q;
         kill_d    = kill_q;
         ldi_d     = ldi_q;
         stk_d     = 1'b0;
         mem_we    = 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Sequencer and program counter
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= bcbe_pkg::ST_FIRST;
         pend_q  <= bcbe_pkg::PK_CMPI;
         page_q  <= 3'(`BCBE_PC_RST >> 7);
         low_q   <= 7'h00;
         ppage_q <= 3'h0;
         skip_q  <= 1'b0;
         kill_q  <= 1'b0;
         ldi_q   <= 1'b0;
         stk_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         pend_q  <= pend_d;
         page_q  <= page_d;
         low_q   <= low_d;
         ppage_q <= ppage_d;
         skip_q  <= skip_d;
         kill_q  <= kill_d;
         ldi_q   <= ldi_d;
         stk_q   <= stk_d;
      end
   end

   // ---------------------------------------------------------------------------
   // Accumulator and flags
   // ---------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= `BCBE_ACC_RST;
         cy_q  <= 1'b0;
         urs_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         cy_q  <= cy_d;
         urs_q <= urs_d;
      end
   end

   assign prog_counter   = {page_q, low_q};
   assign acc            = acc_q;
   assign carry_flag     = cy_q;
   assign upper_ref_flag = urs_q;
   assign stack_use      = stk_q;

   // ---------------------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------------------
   logic apb_wr;
   logic apb_hit;

   assign pready  = 1'b1;
   assign apb_hit = (paddr == `BCBE_REG_CTRL) || (paddr == `BCBE_REG_STAT) || (paddr == `BCBE_REG_PC);
   assign pslverr = psel && penable && !apb_hit;
   assign apb_wr  = psel && penable && pwrite && (paddr == `BCBE_REG_CTRL);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fsel_q <= `BCBE_FSEL_RST;
      end else if (apb_wr) begin
         fsel_q <= pwdata[1:0];   // see (RL11)
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         case (paddr)
            `BCBE_REG_CTRL: begin
               prdata = {30'h0, fsel_q};
            end
            `BCBE_REG_STAT: begin
               prdata = {24'h0, kill_q, skip_q, urs_q, cy_q, acc_q};
            end
            `BCBE_REG_PC: begin
               prdata = {22'h0, page_q, low_q};
            end
            default: begin
               prdata = 32'h0000_0000;
            end
         endcase
      end
   end

endmodule : bcbe_core

`default_nettype wire

// File: include/bcbe_consts.svh
/*
 Constants of the bit, compare and branch execution block: opcodes, fields,
 register offsets and reset values. Assumes a 10-bit instruction word.
*/
//
// How it works
// (RL1) Set-bit forces bit j of memory word at data_pointer to one, one cycle.
// (RL2) Clear-bit forces bit j of memory word at data_pointer to zero, one cycle.
// (RL3) Bit-test skips the next instruction when bit j of memory is zero.
// (RL4) Compares skip when accumulator equals memory, or equals second-word immediate.
// (RL5) In-page branch loads seven-bit address into low counter, page kept.
// (RL6) Long branch: first word gives page, second word gives low address.
// (RL7) Indexed in-page branch: page kept, a6..a4 from second word, low four bits from accumulator.
// (RL8) Indexed long branch: page from second word low bits, low from a6..a4 plus accumulator.
// (RL9) Branch page operand is limited to values zero to seven.
// (RL10) Rotate shifts accumulator right through carry flag.
// (RL11) Logic op combines accumulator and E by selected function into accumulator.
// (RL12) In a run of load-immediates only the first executes.
// (RL13) Table read loads low four program bits to accumulator, uses one stack level.
// (RL14) With upper reference flag set, table read moves upper bit into carry.
// (RL15) Add-immediate keeps carry, skips next when no overflow.
// (RL16) Add-with-carry adds memory and carry, sum to accumulator, carry out to carry.
// (RL17) Carry-test skips next instruction when carry is zero.
// (RL18) Skipped instructions fetch as no-ops, two-word ones lose both words.
`ifndef BCBE_CONSTS_SVH
`define BCBE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Opcodes (casez patterns)
// ----------------------------------------------------------------------------
`define BCBE_OP_SETB     10'b00_0101_11??
`define BCBE_OP_CLRB     10'b00_0100_11??
`define BCBE_OP_SKBZ     10'b00_0010_00??
`define BCBE_OP_CMPM     10'b00_0010_0110
`define BCBE_OP_CMPI     10'b00_0010_0101
`define BCBE_OP_BR       10'b01_1???_????
`define BCBE_OP_BRL      10'b00_0011_????
`define BCBE_OP_BRA      10'b00_0000_0001
`define BCBE_OP_BRLA     10'b00_0001_0000
`define BCBE_OP_ROT      10'b00_0001_1101
`define BCBE_OP_LOGIC    10'b00_0001_1000
`define BCBE_OP_LDI      10'b00_0111_????
`define BCBE_OP_ADDI     10'b00_0110_????
`define BCBE_OP_ADDC     10'b00_0000_1010
`define BCBE_OP_SKCZ     10'b00_0010_1111
`define BCBE_OP_TBL      10'b00_0100_1010
`define BCBE_OP_URSET    10'b00_0001_1100

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define BCBE_TBL_CY_BIT  9
`define BCBE_IDX_HI      6
`define BCBE_IDX_LO      4

// ----------------------------------------------------------------------------
// APB register map and reset values
// ----------------------------------------------------------------------------
`define BCBE_REG_CTRL    12'h000
`define BCBE_REG_STAT    12'h004
`define BCBE_REG_PC      12'h008
`define BCBE_FSEL_RST    2'h0
`define BCBE_PC_RST      10'h000
`define BCBE_ACC_RST     4'h0

`endif

// File: include/bcbe_pkg.sv
/*
 Types of the bit, compare and branch execution block.
 Assumes bcbe_consts.svh is compiled alongside.
*/
`default_nettype none

package bcbe_pkg;

   // Sequencer state, one-hot
   typedef enum logic [1:0] {
      ST_FIRST  = 2'b01,
      ST_SECOND = 2'b10
   } bcbe_state_e;

   // Kind of a pending two-word instruction
   typedef enum logic [3:0] {
      PK_CMPI = 4'b0001,
      PK_BRL  = 4'b0010,
      PK_BRA  = 4'b0100,
      PK_BRLA = 4'b1000
   } bcbe_pend_e;

   // Logic function chosen by gate_function_select
   typedef enum logic [1:0] {
      GF_AND  = 2'h0,
      GF_OR   = 2'h1,
      GF_XOR  = 2'h2,
      GF_XNOR = 2'h3
   } bcbe_gfn_e;

endpackage : bcbe_pkg

`default_nettype wire

// File: verilog/bcbe_alu.sv
/*
 Combinational arithmetic of the execution block: adds, rotate and logic.
 Assumes operands are stable for the whole instruction cycle.
*/
`default_nettype none

module bcbe_alu (
   // Operands
   input  wire logic [3:0] acc,
   input  wire logic [3:0] opnd,
   input  wire logic       carry_in,
   input  wire logic       use_carry,
   input  wire logic [1:0] gate_function_select,
   // Results
   output logic      [3:0] sum,
   output logic            sum_carry,
   output logic      [3:0] rot,
   output logic            rot_carry,
   output logic      [3:0] gate
);

   logic [4:0] wide;

   // ---------------------------------------------------------------------------
   // Adder
   // ---------------------------------------------------------------------------
   always_comb begin
      wide      = {1'b0, acc} + {1'b0, opnd} + {4'h0, carry_in & use_carry};   // see (RL15) (RL16)
      sum       = wide[3:0];
      sum_carry = wide[4];
   end

   // ---------------------------------------------------------------------------
   // Rotate right through carry and logic unit
   // ---------------------------------------------------------------------------
   always_comb begin
      rot       = {carry_in, acc[3:1]};   // see (RL10)
      rot_carry = acc[0];
      case (bcbe_pkg::bcbe_gfn_e'(gate_function_select))   // see (RL11)
         bcbe_pkg::GF_AND: begin
            gate = acc & opnd;
         end
         bcbe_pkg::GF_OR: begin
            gate = acc | opnd;
         end
         bcbe_pkg::GF_XOR: begin
            gate = acc ^ opnd;
         end
         default: begin
            gate = ~(acc ^ opnd);
         end
      endcase
   end

endmodule : bcbe_alu

`default_nettype wire

// File: bench/bcbe_core_sva.sv
/*
 Checker of the execution block, bound to bcbe_core.
 Assumes that the instructions it watches are not themselves skipped.
*/
`default_nettype none

module bcbe_core_sva (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // Instruction side
   input wire logic       step,
   input wire logic [9:0] instr,
   input wire logic [9:0] prog_counter,
   input wire logic [3:0] mem_rdata,
   input wire logic [3:0] mem_wdata,
   input wire logic       mem_we,
   input wire logic [9:0] tbl_data,
   input wire logic       stack_use,
   // Core state
   input wire logic [3:0] acc,
   input wire logic       carry_flag,
   input wire logic       upper_ref_flag
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic pend_q;

   // ------------------------------------------------------------------
   // Marks a word that follows a two-word first word
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 1'b0;
      end else if (step) begin
         pend_q <= (instr[9:4] == 6'h03) || (instr == 10'h001) || (instr == 10'h010) || (instr == 10'h025);
      end
   end

   // ------------------------------------------------------------------
   // Sequences and properties
   // ------------------------------------------------------------------
   sequence s_brl;
      step && instr[9:4] == 6'h03 ##1 step;
   endsequence
   sequence s_bra;
      step && instr == 10'h001 ##1 step;
   endsequence
   sequence s_brla;
      step && instr == 10'h010 ##1 step;
   endsequence

   property p_setb;
      step && instr[9:2] == 8'h17 |-> mem_we && mem_wdata == (mem_rdata | (4'h1 << instr[1:0]));
   endproperty
   property p_clrb;
      step && instr[9:2] == 8'h13 |-> mem_we && mem_wdata == (mem_rdata & ~(4'h1 << instr[1:0]));
   endproperty
   property p_br;
      step && instr[9:7] == 3'b011 && !pend_q |=> prog_counter == {$past(prog_counter[9:7]), $past(instr[6:0])};
   endproperty
   property p_brl;
      s_brl |=> prog_counter == {$past(instr[2:0], 2), $past(instr[6:0])};
   endproperty
   property p_bra;
      s_bra |=> prog_counter == {$past(prog_counter[9:7]), $past(instr[6:4]), $past(acc)};
   endproperty
   property p_brla;
      s_brla |=> prog_counter == {$past(instr[2:0]), $past(instr[6:4]), $past(acc)};
   endproperty
   property p_rot;
      step && instr == 10'h01d |=> acc == {$past(carry_flag), $past(acc[3:1])} && carry_flag == $past(acc[0]);
   endproperty
   property p_stack;
      step && instr == 10'h04a |=> stack_use ##1 !stack_use;
   endproperty
   property p_tbl;
      step && instr == 10'h04a |=> acc == $past(tbl_data[3:0])
         && carry_flag == ($past(upper_ref_flag) ? $past(tbl_data[9]) : $past(carry_flag));
   endproperty
   property p_addc;
      step && instr == 10'h00a |=> {carry_flag, acc} == 5'($past(acc)) + 5'($past(mem_rdata)) + 5'($past(carry_flag));
   endproperty
   property p_idle;
      !step |=> $stable(acc) && $stable(prog_counter) && $stable(carry_flag);
   endproperty

   a_setb:  assert property (p_setb)  else $error("set bit write wrong");
   a_clrb:  assert property (p_clrb)  else $error("clear bit write wrong");
   a_br:    assert property (p_br)    else $error("in-page branch wrong");
   a_brl:   assert property (p_brl)   else $error("long branch wrong");
   a_bra:   assert property (p_bra)   else $error("indexed branch wrong");
   a_brla:  assert property (p_brla)  else $error("indexed long branch wrong");
   a_rot:   assert property (p_rot)   else $error("rotate wrong");
   a_stack: assert property (p_stack) else $error("stack use pulse wrong");
   a_tbl:   assert property (p_tbl)   else $error("table read wrong");
   a_addc:  assert property (p_addc)  else $error("add with carry wrong");
   a_idle:  assert property (p_idle)  else $error("state moved without step");

endmodule : bcbe_core_sva

bind bcbe_core bcbe_core_sva u_sva (
   .clk(clk), .rst_b(rst_b), .step(step), .instr(instr), .prog_counter(prog_counter),
   .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .tbl_data(tbl_data),
   .stack_use(stack_use), .acc(acc), .carry_flag(carry_flag), .upper_ref_flag(upper_ref_flag)
);

`default_nettype wire

// File: bench/bit_compare_branch_exec_bench.sv
/*
 Self-checking bench of the execution block.
 Assumes the bench models data memory and table memory itself.
*/
`default_nettype none

module bit_compare_branch_exec_bench;
   timeunit 1ns;
   timeprecision 100ps;

`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end

   logic        clk, rst_b, step, mem_we, stack_use, carry_flag, upper_ref_flag;
   logic        psel, penable, pwrite, pready, pslverr, er;
   logic [9:0]  instr, prog_counter, tbl_data;
   logic [3:0]  mem_q, mem_wdata, e_reg, acc;
   logic [2:0]  tbl_page;
   logic [6:0]  tbl_addr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_errors, checked;
   logic [3:0]  gexp [4] = '{4'h8, 4'hd, 4'h5, 4'ha};

   bcbe_core dut (
      .clk(clk), .rst_b(rst_b), .step(step), .instr(instr), .prog_counter(prog_counter),
      .mem_rdata(mem_q), .mem_wdata(mem_wdata), .mem_we(mem_we), .e_reg(e_reg),
      .tbl_page(tbl_page), .tbl_addr(tbl_addr), .tbl_data(tbl_data), .stack_use(stack_use),
      .acc(acc), .carry_flag(carry_flag), .upper_ref_flag(upper_ref_flag),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   // ------------------------------------------------------------------
   // Clock, memory and table models
   // ------------------------------------------------------------------
   always #12.5 clk = ~clk;
   always @(posedge clk) if (mem_we) mem_q <= mem_wdata;
   assign tbl_data = {tbl_addr[0], 5'h00, ~tbl_addr[3:0]};

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic ex(input logic [9:0] w);
      step <= 1'b1;
      instr <= w;
      @(posedge clk);
   endtask : ex

   task automatic idle();
      step <= 1'b0;
      @(posedge clk);
   endtask : idle

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      clk = 0; rst_b = 0; step = 0; instr = 0; mem_q = 0; e_reg = 4'hc; tbl_page = 3'h3;
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; n_errors = 0; checked = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("acc", 4'h0, acc)
      `CHK("pc", 10'h000, prog_counter)
      for (int j = 0; j < 4; j++) ex(10'h05c + 10'(j));
      idle();
      `CHK("mem", 4'hf, mem_q)
      ex(10'h04e);
      idle();
      `CHK("mem", 4'hb, mem_q)
      ex(10'h073); ex(10'h022); ex(10'h079); ex(10'h023); ex(10'h076);
      idle();
      `CHK("acc", 4'h6, acc)
      ex(10'h026); ex(10'h07b); ex(10'h026); ex(10'h071); ex(10'h025); ex(10'h0bb);
      ex(10'h025); ex(10'h0b5); ex(10'h072); ex(10'h025); ex(10'h0b0); ex(10'h074);
      idle();
      `CHK("acc", 4'h4, acc)
      ex(10'h026); ex(10'h077); ex(10'h078); ex(10'h079);
      idle();
      `CHK("acc", 4'h7, acc)
      ex(10'h1d5);
      idle();
      `CHK("pc", 10'h055, prog_counter)
      ex(10'h035); ex(10'h192);
      idle();
      `CHK("pc", 10'h292, prog_counter)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("pc reg", 32'h292, rd)
      ex(10'h037); ex(10'h1ff);
      idle();
      `CHK("pc", 10'h3ff, prog_counter)
      ex(10'h001); ex(10'h1f0);
      idle();
      `CHK("pc", 10'h3f7, prog_counter)
      ex(10'h010); ex(10'h1b2);
      idle();
      `CHK("pc", 10'h137, prog_counter)
      ex(10'h01d); ex(10'h01d);
      idle();
      `CHK("acc", 4'h9, acc)
      `CHK("carry", 1'b1, carry_flag)
      ex(10'h02f); ex(10'h072); ex(10'h01d); ex(10'h02f); ex(10'h075);
      idle();
      `CHK("acc", 4'h9, acc)
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, 12'h000, 32'(f));
         apb(1'b0, 12'h000, 32'h0);
         `CHK("ctrl", 32'(f), rd)
         ex(10'h079); ex(10'h018);
         idle();
         `CHK("acc", gexp[f], acc)
      end
      ex(10'h079); ex(10'h063); ex(10'h071); ex(10'h065); ex(10'h072);
      idle();
      `CHK("acc", 4'h2, acc)
      `CHK("carry", 1'b0, carry_flag)
      ex(10'h026); ex(10'h076); ex(10'h00a); ex(10'h00a);
      idle();
      `CHK("acc", 4'hd, acc)
      `CHK("carry", 1'b0, carry_flag)
      ex(10'h075); ex(10'h04a);
      idle();
      `CHK("acc", 4'ha, acc)
      `CHK("carry", 1'b0, carry_flag)
      ex(10'h01c); ex(10'h073); ex(10'h04a);
      idle();
      `CHK("acc", 4'hc, acc)
      `CHK("carry", 1'b1, carry_flag)
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("stat", 32'h3c, rd)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("slverr", 1'b1, er)
      `CHK("rdata", 32'h0, rd)
      tally_and_finish();
   end

endmodule : bit_compare_branch_exec_bench

`default_nettype wire
